// [hdl/prg_core.sv]
`timescale 1ns/1ps
// Function
// - Power-up reset clears every macrocell register low on edges of the system clock.
// - Registered outputs show high after power-up reset.
// - Preload forces each register high or low individually.
// - 64-bit eight-byte signature stays readable regardless of security.
// - Security set blocks pattern verify and register preload.
// - Security acts at once; programmer sets it last.
// - Each cell: registered, comb I/O, comb output, or input.
// - Exactly one of three architecture modes is active.
// - Registered cells use clock pin and output-enable pin.
// - Combinatorial cell in registered mode: one OE term, seven sum.
module prg_core
  import prg_pkg::*;
#(
  parameter int CELLS = PRG_CELLS,
  parameter int PTERMS = PRG_PTERMS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CLK_PIN,
  input wire logic OE_PIN_N,
  input wire logic [CELLS-1:0] IN_PINS,
  input wire logic [CELLS-1:0] IN_PINS_DRIVEN,
  input wire logic [CELLS-1:0] IO_IN,
  input wire logic [CELLS-1:0] IO_IN_DRIVEN,
  output logic [CELLS-1:0] IO_OUT,
  output logic [CELLS-1:0] IO_OE,
  input wire logic [CELLS*PTERMS-1:0] PTERMS_IN,
  input wire logic [1:0] MODE_CFG,
  input wire logic [2*CELLS-1:0] CELL_CFG,
  input wire logic PRELOAD_REQ,
  input wire logic [CELLS-1:0] PRELOAD_DATA,
  input wire logic [CELLS-1:0] PATTERN_IN,
  input wire logic VERIFY_REQ,
  output logic [CELLS-1:0] VERIFY_DATA,
  output logic VERIFY_VALID,
  input wire logic SIG_WR,
  input wire logic [2:0] SIG_ADDR,
  input wire logic [7:0] SIG_WDATA,
  output logic [7:0] SIG_RDATA,
  input wire logic SECURE_SET,
  input wire logic ERASE,
  output logic SECURED,
  output logic POR_BUSY,
  output logic [1:0] MODE_ACTIVE,
  output logic [CELLS-1:0] FEEDBACK
);

  // ==========================================================================
  // Power-up reset interval counter.
  logic [5:0] por_cnt_reg;
  logic [5:0] por_cnt_next;
  wire por_active = (por_cnt_reg != PRG_POR_CNT_W);

  // Count out the power-up interval after RST; registers clear meanwhile.
  assign por_cnt_next = por_active ? (por_cnt_reg + 6'h01) : por_cnt_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      por_cnt_reg <= 6'h00;
    end else begin
      por_cnt_reg <= por_cnt_next;
    end
  end

  // ==========================================================================
  // Security fuse and signature store.
  logic secure_reg;
  logic [7:0] sig_mem [PRG_SIG_BYTES];
  logic [7:0] sig_rdata_reg;

  // The fuse holds until reset or a full erase; erase wins since it clears all.
  always_ff @(posedge CLK) begin
    if (RST) begin
      secure_reg <= 1'b0;
    end else if (ERASE) begin
      secure_reg <= 1'b0;
    end else if (SECURE_SET) begin
      secure_reg <= 1'b1;
    end
  end

  // Signature bytes are written and read regardless of the fuse.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sig_rdata_reg <= PRG_BYTE_RESET;
    end else begin
      sig_rdata_reg <= sig_mem[SIG_ADDR];
    end
  end

  // Signature array is cleared by erase and written per byte.
  always_ff @(posedge CLK) begin
    for (int i = 0; i < PRG_SIG_BYTES; i++) begin
      if (RST || ERASE) begin
        sig_mem[i] <= PRG_BYTE_RESET;
      end else if (SIG_WR && (SIG_ADDR == 3'(i))) begin
        sig_mem[i] <= SIG_WDATA;
      end
    end
  end

  // ==========================================================================
  // Verify readback of the pattern, gated at once by the fuse.
  logic [CELLS-1:0] verify_data_reg;
  logic verify_valid_reg;
  // The live fuse value includes a set in this very cycle.
  wire secured_now = secure_reg || (SECURE_SET && !ERASE);
  wire verify_ok = VERIFY_REQ && !secured_now;
  wire preload_ok = PRELOAD_REQ && !secured_now && !por_active;

  // Refused verifies return zero data with no valid strobe.
  always_ff @(posedge CLK) begin
    if (RST) begin
      verify_data_reg <= '0;
      verify_valid_reg <= 1'b0;
    end else begin
      verify_data_reg <= verify_ok ? PATTERN_IN : '0;
      verify_valid_reg <= verify_ok;
    end
  end

  // ==========================================================================
  // Clock pin edge detection; edges are ignored during power-up reset.
  logic clk_pin_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_pin_reg <= 1'b0;
    end else begin
      clk_pin_reg <= CLK_PIN;
    end
  end
  wire clk_rise = CLK_PIN && !clk_pin_reg && !por_active;

  // ==========================================================================
  // Mode decode: an illegal code falls back to registered mode.
  function automatic logic [1:0] prg_mode_fix(input logic [1:0] m);
    prg_mode_fix = (m == 2'h3) ? 2'(PRG_MODE_REGISTERED) : m;
  endfunction : prg_mode_fix
  wire [1:0] mode_sel = prg_mode_fix(MODE_CFG);

  // Undriven pins read high through the weak pull-ups.
  wire [CELLS-1:0] in_seen = IN_PINS | ~IN_PINS_DRIVEN;
  wire [CELLS-1:0] io_seen = IO_IN | ~IO_IN_DRIVEN;

  // ==========================================================================
  // Macrocells.
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      prg_macrocell u_cell (
        .clk(CLK),
        .por_clear(RST || por_active),
        .clk_edge(clk_rise),
        .preload_en(preload_ok),
        .preload_val(PRELOAD_DATA[g]),
        .mode(mode_sel),
        .cfg(CELL_CFG[2*g+1:2*g]),
        .pterms(PTERMS_IN[g*PTERMS+PTERMS-1:g*PTERMS]),
        .oe_pin_n(OE_PIN_N),
        .pin_in(io_seen[g] & in_seen[g]),
        .pin_out(IO_OUT[g]),
        .pin_oe(IO_OE[g]),
        .feedback(FEEDBACK[g])
      );
    end
  endgenerate

  // Status outputs.
  assign SECURED = secure_reg;
  assign POR_BUSY = por_active;
  assign MODE_ACTIVE = mode_sel;
  assign SIG_RDATA = sig_rdata_reg;
  assign VERIFY_DATA = verify_data_reg;
  assign VERIFY_VALID = verify_valid_reg;

endmodule : prg_core

// [include/prg_pkg.sv]
package prg_pkg;

  // ==========================================================================
  // Sizes of the device.
  localparam int PRG_CELLS = 8;
  localparam int PRG_SIG_BYTES = 8;
  localparam int PRG_PTERMS = 8;

  // ==========================================================================
  // Power-up reset interval, in ns, and the clock that counts it.
  localparam int PRG_CLK_PERIOD_NS = 20;
  localparam int PRG_POR_MIN_NS = 600;
  localparam int PRG_POR_MAX_NS = 1000;
  // Least time rounds up to whole cycles.
  localparam int PRG_POR_CYCLES =
    (PRG_POR_MIN_NS + PRG_CLK_PERIOD_NS - 1) / PRG_CLK_PERIOD_NS;
  localparam logic [5:0] PRG_POR_CNT_W = 6'h1E;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] PRG_CELL_RESET = 8'h00;
  localparam logic [7:0] PRG_BYTE_RESET = 8'h00;

  // Architecture modes.
  typedef enum logic [1:0] {
    PRG_MODE_SIMPLE,
    PRG_MODE_COMPLEX,
    PRG_MODE_REGISTERED
  } prg_mode_t;

  // Macrocell configurations.
  typedef enum logic [1:0] {
    PRG_CELL_REG_OUT,
    PRG_CELL_COMB_IO,
    PRG_CELL_COMB_OUT,
    PRG_CELL_INPUT
  } prg_cell_t;

endpackage : prg_pkg

// [hdl/prg_macrocell.sv]
`timescale 1ns/1ps
// ============================================================================
// One macrocell: register, sum term and output enable selection.
module prg_macrocell
  import prg_pkg::*;
(
  input wire logic clk,
  input wire logic por_clear,
  input wire logic clk_edge,
  input wire logic preload_en,
  input wire logic preload_val,
  input wire logic [1:0] mode,
  input wire logic [1:0] cfg,
  input wire logic [PRG_PTERMS-1:0] pterms,
  input wire logic oe_pin_n,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic feedback
);

  logic q_reg;
  logic q_next;
  wire is_reg = (mode == PRG_MODE_REGISTERED) && (cfg == PRG_CELL_REG_OUT);
  wire is_input = (cfg == PRG_CELL_INPUT);
  wire is_comb_io = (cfg == PRG_CELL_COMB_IO);
  // Registered cells sum all terms; combinatorial ones in registered or
  // complex mode give term 0 to output enable and sum the other seven.
  wire pt_oe_used = (mode != PRG_MODE_SIMPLE) && !is_reg;
  wire sum_all = |pterms;
  wire sum_seven = |pterms[PRG_PTERMS-1:1];
  wire sum_term = pt_oe_used ? sum_seven : sum_all;

  // Register: cleared on power-up, preloaded, or clocked from the clock pin.
  assign q_next = preload_en ? preload_val :
                  (clk_edge ? sum_term : q_reg);
  always_ff @(posedge clk) begin
    if (por_clear) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Output selection; registered outputs drive the inverse of the register.
  always_comb begin
    pin_out = is_reg ? ~q_reg : sum_term;
    if (is_input) begin
      pin_oe = 1'b0;
    end else if (is_reg) begin
      pin_oe = ~oe_pin_n;
    end else if (pt_oe_used) begin
      pin_oe = pterms[0];
    end else begin
      pin_oe = 1'b1;
    end
  end

  // Feedback: register for registered cells, pin for I/O or inputs.
  assign feedback = is_reg ? q_reg :
                    ((is_input || is_comb_io) ? pin_in : sum_term);

endmodule : prg_macrocell

// [dv/prg_board_model.sv]
`timescale 1ns/1ps
// ====================
// Board side that drives the device clock pin.
module prg_board_model
(
  input wire logic clk,
  input wire logic por_busy,
  input wire logic tick,
  output logic clk_pin
);
  // Pin stays low in power-up; a rise lags the request so inputs settle.
  always_ff @(posedge clk) begin
    clk_pin <= tick && !por_busy;
  end
endmodule : prg_board_model

// [dv/prg_core_properties.sv]
`timescale 1ns/1ps
// ====================
// Port checks on the device core.
module prg_core_properties
  import prg_pkg::*;
#(
  parameter int CELLS = PRG_CELLS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] MODE_CFG,
  input wire logic [2*CELLS-1:0] CELL_CFG,
  input wire logic [CELLS-1:0] IO_OUT,
  input wire logic [CELLS-1:0] PATTERN_IN,
  input wire logic VERIFY_REQ,
  input wire logic [CELLS-1:0] VERIFY_DATA,
  input wire logic VERIFY_VALID,
  input wire logic SIG_WR,
  input wire logic [2:0] SIG_ADDR,
  input wire logic [7:0] SIG_WDATA,
  input wire logic [7:0] SIG_RDATA,
  input wire logic SECURE_SET,
  input wire logic ERASE,
  input wire logic SECURED,
  input wire logic POR_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Read back, fuse, signature and power-up relations.
  a_verify_echo: assert property (
    VERIFY_REQ && !SECURED && !SECURE_SET
    |=> VERIFY_VALID && VERIFY_DATA == $past(PATTERN_IN))
    else $error("read back missing");
  a_verify_locked: assert property (
    SECURED |=> !VERIFY_VALID) else $error("read back not refused");
  a_fuse_sticky: assert property (
    SECURED && !ERASE |=> SECURED) else $error("fuse dropped");
  a_fuse_now: assert property (
    SECURE_SET && !ERASE |=> SECURED) else $error("fuse late");
  a_erase_clears: assert property (
    ERASE |=> !SECURED) else $error("erase kept fuse");
  a_sig_read: assert property (
    SIG_WR && !ERASE && !POR_BUSY ##1 !SIG_WR && !ERASE
    && SIG_ADDR == $past(SIG_ADDR) |=> SIG_RDATA == $past(SIG_WDATA, 2))
    else $error("signature byte lost");
  a_por_span: assert property (
    $fell(RST) |-> POR_BUSY [*8] ##20 POR_BUSY ##[1:23] !POR_BUSY)
    else $error("power-up span wrong");
  a_por_high: assert property (
    POR_BUSY && MODE_CFG == 2'h2 && CELL_CFG[1:0] == 2'h0 |-> IO_OUT[0])
    else $error("output low in power-up");
endmodule : prg_core_properties

bind prg_core prg_core_properties #(.CELLS(CELLS)) u_props (
  .CLK(CLK), .RST(RST), .MODE_CFG(MODE_CFG), .CELL_CFG(CELL_CFG),
  .IO_OUT(IO_OUT), .PATTERN_IN(PATTERN_IN), .VERIFY_REQ(VERIFY_REQ),
  .VERIFY_DATA(VERIFY_DATA), .VERIFY_VALID(VERIFY_VALID),
  .SIG_WR(SIG_WR), .SIG_ADDR(SIG_ADDR), .SIG_WDATA(SIG_WDATA),
  .SIG_RDATA(SIG_RDATA), .SECURE_SET(SECURE_SET), .ERASE(ERASE),
  .SECURED(SECURED), .POR_BUSY(POR_BUSY));

// [dv/prg_core_tb.sv]
`timescale 1ns/1ps
// ====================
// Self-checking bench for the device core.
module prg_core_tb;
  import prg_pkg::*;
  logic clk = 0, rst = 1, tick = 0, clk_pin, oe_n = 0, pre_req = 0;
  logic ver_req = 0, sig_wr = 0, sec_set = 0, erase = 0, ver_valid;
  logic [7:0] in_pins = 8'h00, in_drv = 8'hFF, io_in = 8'h00;
  logic [7:0] io_drv = 8'hFF, pre_data = 8'h00, pattern = 8'h00;
  logic [7:0] sig_wdata = 8'h00, io_out, io_oe, ver_data, sig_rdata, fb;
  logic [63:0] pterms = 64'h0;
  logic [1:0] mode = 2'h2, mode_act;
  logic [15:0] cell_cfg = 16'h0000;
  logic [2:0] sig_addr = 3'h0;
  logic secured, por_busy;
  int failures = 0, n_checks = 0, cycles = 0;
  // Clock and hang guard.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done;
    end
  end
  prg_board_model u_prg_board_model (.clk(clk), .por_busy(por_busy),
    .tick(tick), .clk_pin(clk_pin));
  prg_core u_prg_core (.CLK(clk), .RST(rst), .CLK_PIN(clk_pin),
    .OE_PIN_N(oe_n), .IN_PINS(in_pins), .IN_PINS_DRIVEN(in_drv),
    .IO_IN(io_in), .IO_IN_DRIVEN(io_drv), .IO_OUT(io_out), .IO_OE(io_oe),
    .PTERMS_IN(pterms), .MODE_CFG(mode), .CELL_CFG(cell_cfg),
    .PRELOAD_REQ(pre_req), .PRELOAD_DATA(pre_data), .PATTERN_IN(pattern),
    .VERIFY_REQ(ver_req), .VERIFY_DATA(ver_data), .VERIFY_VALID(ver_valid),
    .SIG_WR(sig_wr), .SIG_ADDR(sig_addr), .SIG_WDATA(sig_wdata),
    .SIG_RDATA(sig_rdata), .SECURE_SET(sec_set), .ERASE(erase),
    .SECURED(secured), .POR_BUSY(por_busy), .MODE_ACTIVE(mode_act),
    .FEEDBACK(fb));
  // Compares one value and counts the result.
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task t_power_up;
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    pre_req <= 1;
    pre_data <= 8'hFF;
    @(posedge clk);
    pre_req <= 0;
    #1 chk("power-up out", io_out, 8'hFF);
    // Two busy edges have passed here; count the rest of the interval.
    while (por_busy) begin
      @(posedge clk);
      #1 n++;
    end
    chk("power-up span", 16'(n + 2), 16'(PRG_POR_CYCLES));
    $display("power_up done");
  endtask : t_power_up
  task t_preload;
    @(posedge clk);
    pre_req <= 1;
    pre_data <= 8'hA5;
    @(posedge clk);
    pre_req <= 0;
    pterms <= {8{8'h80}};
    tick <= 1;
    #1 chk("preload out", io_out, 8'h5A);
    chk("reg enable", io_oe, 8'hFF);
    @(posedge clk);
    tick <= 0;
    repeat (3) @(posedge clk);
    #1 chk("clocked out", io_out, 8'h00);
    $display("preload done");
  endtask : t_preload
  task t_secure;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sig_wr <= 1;
      sig_addr <= 3'(i);
      sig_wdata <= 8'(8'hC0 + i);
    end
    @(posedge clk);
    sig_wr <= 0;
    ver_req <= 1;
    pattern <= 8'h3C;
    @(posedge clk);
    ver_req <= 0;
    #1 chk("verify", {ver_valid, ver_data}, 9'h13C);
    @(posedge clk);
    {sec_set, ver_req, pre_req} <= 3'h7;
    pre_data <= 8'h00;
    @(posedge clk);
    {sec_set, ver_req, pre_req} <= 3'h0;
    #1 chk("fuse", secured, 1'h1);
    chk("locked", {ver_valid, io_out}, 9'h000);
    chk("locked data", ver_data, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sig_addr <= 3'(i);
      @(posedge clk);
      #1 chk("signature", sig_rdata, 8'(8'hC0 + i));
    end
    erase <= 1;
    @(posedge clk);
    erase <= 0;
    #1 chk("erased", secured, 1'h0);
    // After erase both verify and preload must be accepted again.
    {ver_req, pre_req} <= 2'h3;
    pre_data <= 8'h00;
    @(posedge clk);
    {ver_req, pre_req} <= 2'h0;
    #1 chk("reopened", {ver_valid, ver_data}, 9'h13C);
    chk("preload again", io_out, 8'hFF);
    chk("signature erased", sig_rdata, PRG_BYTE_RESET);
    $display("secure done");
  endtask : t_secure
  task t_cells;
    @(posedge clk);
    {cell_cfg, in_drv, io_drv} <= 32'hFFFF0000;
    @(posedge clk);
    #1 chk("pull-up", {io_oe, fb}, 16'h00FF);
    {in_drv, io_drv} <= 16'hFFFF;
    @(posedge clk);
    #1 chk("driven low", fb, 8'h00);
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      @(posedge clk);
      #1 chk("mode", mode_act, (m == 3) ? 2'h2 : 2'(m));
    end
    $display("cells done");
  endtask : t_cells
  // Combinatorial cells: term 0 as enable, seven summed; OE pin gating of registered cells.
  task t_comb;
    @(posedge clk);
    mode <= 2'h2;
    cell_cfg <= 16'hAAAA;
    pterms <= {8{8'h01}};
    @(posedge clk);
    #1 chk("term enable", {io_oe, io_out}, 16'hFF00);
    pterms <= {8{8'h80}};
    @(posedge clk);
    #1 chk("seven terms", {io_oe, io_out}, 16'h00FF);
    mode <= 2'h0;
    pterms <= {8{8'h01}};
    @(posedge clk);
    #1 chk("simple mode", {io_oe, io_out}, 16'hFFFF);
    {mode, cell_cfg, oe_n} <= {2'h2, 16'h0000, 1'h1};
    @(posedge clk);
    #1 chk("enable pin", io_oe, 8'h00);
    oe_n <= 1'h0;
    $display("comb done");
  endtask : t_comb
  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Main sequence.
  initial begin
    t_power_up;
    t_preload;
    t_secure;
    t_cells;
    t_comb;
    test_done;
  end
endmodule : prg_core_tb
